//--- ilsel_ctrl.sv
`timescale 1ns/1ps
module ilsel_ctrl
(
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [31:0]      prdata_out,
   input  wire logic        primary_fail_in,
   input  wire logic        secondary_fail_in,
   input  wire logic        feedback_fail_in,
   input  wire logic        ref_select_pin_in,
   output logic             use_secondary_out,
   output logic [15:0]      primary_div_out,
   output logic [15:0]      secondary_div_out,
   output logic             tune_midsupply_out,
   output logic             pump_tristate_out,
   output logic [4:0]       zero_res_onehot_out,
   output logic             zero_res_external_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]          pri_lo;
      logic [7:0]          pri_hi;
      logic [7:0]          sec_lo;
      logic [7:0]          sec_hi;
      logic [7:0]          misc;
      logic [7:0]          zres;
      ilsel_pkg::ilsel_ref_t sel;
      logic [31:0]         rdata;
      logic [15:0]         pri_div;
      logic [15:0]         sec_div;
      logic                tune_mid;
      logic                pump_tri;
      logic [4:0]          rz_onehot;
      logic                rz_ext;
   } ilsel_state_t;

   ilsel_state_t s;
   ilsel_state_t next_s;

   logic        setup;
   logic        access;
   logic        hit;
   logic        wr;
   logic        clk_fail;
   logic [15:0] pri_word;
   logic [15:0] sec_word;

   // Divider word 0 or 1 already divides by one, so bypass folds in here
   function automatic logic [15:0] eff_div(input logic [15:0] word,
                                           input logic        bypass);
      if (bypass || word <= 16'h0001)
         eff_div = 16'h0001;
      else
         eff_div = word;
   endfunction

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   assign setup  = psel_in && !penable_in;
   assign access = psel_in && penable_in;
   assign hit    = paddr_in == ilsel_pkg::PRI_DIV_LO_ADDR || paddr_in == ilsel_pkg::PRI_DIV_HI_ADDR
                || paddr_in == ilsel_pkg::SEC_DIV_LO_ADDR || paddr_in == ilsel_pkg::SEC_DIV_HI_ADDR
                || paddr_in == ilsel_pkg::MISC_ADDR || paddr_in == ilsel_pkg::ZRES_ADDR
                || paddr_in == ilsel_pkg::STATUS_ADDR;
   assign wr     = access && pwrite_in && hit && pstrb_in[0];

   assign pready_out  = 1'b1;
   assign pslverr_out = access && !hit;  // Unmapped address answers with an error

   // Failure seen by the active loop: feedback or the reference in use
   assign clk_fail = feedback_fail_in
                  || (s.sel == ilsel_pkg::ILSEL_SEC ? secondary_fail_in : primary_fail_in);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;

      // Register writes; reserved bits are masked off
      // reserved bits zero
      if (wr)
      begin
         case (paddr_in)
            ilsel_pkg::PRI_DIV_LO_ADDR: next_s.pri_lo = pwdata_in[7:0];
            ilsel_pkg::PRI_DIV_HI_ADDR: next_s.pri_hi = pwdata_in[7:0];
            ilsel_pkg::SEC_DIV_LO_ADDR: next_s.sec_lo = pwdata_in[7:0];
            ilsel_pkg::SEC_DIV_HI_ADDR: next_s.sec_hi = pwdata_in[7:0];
            ilsel_pkg::MISC_ADDR:       next_s.misc   = pwdata_in[7:0] & ilsel_pkg::MISC_MASK;
            ilsel_pkg::ZRES_ADDR:       next_s.zres   = pwdata_in[7:0] & ilsel_pkg::ZRES_MASK;
            default:                    next_s.rdata  = s.rdata;
         endcase
      end

      // Read data is latched in the setup cycle and held through access
      if (setup)
      begin
         case (paddr_in)
            ilsel_pkg::PRI_DIV_LO_ADDR: next_s.rdata = {24'h000000, s.pri_lo};
            ilsel_pkg::PRI_DIV_HI_ADDR: next_s.rdata = {24'h000000, s.pri_hi};
            ilsel_pkg::SEC_DIV_LO_ADDR: next_s.rdata = {24'h000000, s.sec_lo};
            ilsel_pkg::SEC_DIV_HI_ADDR: next_s.rdata = {24'h000000, s.sec_hi};
            ilsel_pkg::MISC_ADDR:       next_s.rdata = {24'h000000, s.misc};
            ilsel_pkg::ZRES_ADDR:       next_s.rdata = {24'h000000, s.zres};
            ilsel_pkg::STATUS_ADDR:     next_s.rdata = {28'h0000000, s.pump_tri, s.tune_mid,
                                                        clk_fail, s.sel == ilsel_pkg::ILSEL_SEC};
            default:                    next_s.rdata = 32'h00000000;
         endcase
      end

      // Reference selection
      // pin selects
      if (s.misc[ilsel_pkg::MISC_PIN_BIT])
         next_s.sel = ref_select_pin_in ? ilsel_pkg::ILSEL_SEC : ilsel_pkg::ILSEL_PRI;
      else
      begin
         case (s.misc[3:2])
            ilsel_pkg::MODE_PRI: next_s.sel = ilsel_pkg::ILSEL_PRI;
            ilsel_pkg::MODE_SEC: next_s.sel = ilsel_pkg::ILSEL_SEC;
            ilsel_pkg::MODE_REVERT:
            begin
               // Primary always wins back once it is healthy
               if (!primary_fail_in)
                  next_s.sel = ilsel_pkg::ILSEL_PRI;
               else if (!secondary_fail_in)
                  next_s.sel = ilsel_pkg::ILSEL_SEC;
            end
            default:
            begin
               // Nonrevertive: switch only away from a failed input
               if (s.sel == ilsel_pkg::ILSEL_PRI && primary_fail_in && !secondary_fail_in)
                  next_s.sel = ilsel_pkg::ILSEL_SEC;
               else if (s.sel == ilsel_pkg::ILSEL_SEC && secondary_fail_in && !primary_fail_in)
                  next_s.sel = ilsel_pkg::ILSEL_PRI;
            end
         endcase
      end

      // Divider ratios
      // primary bypass
      next_s.pri_div = eff_div(pri_word, s.misc[ilsel_pkg::MISC_PRI_BYP_BIT]);
      next_s.sec_div = eff_div(s.misc[ilsel_pkg::MISC_INDEP_BIT] ? sec_word : pri_word,
                               s.misc[ilsel_pkg::MISC_SEC_BYP_BIT]);

      next_s.tune_mid = clk_fail && s.misc[ilsel_pkg::MISC_MIDSUP_BIT];
      next_s.pump_tri = clk_fail && !s.misc[ilsel_pkg::MISC_MIDSUP_BIT];

      // resistor decode; undefined codes above 1000 fall to external
      next_s.rz_ext    = s.zres[3];
      next_s.rz_onehot = 5'h00;
      if (!s.zres[3])
      begin
         case (s.zres[2:0])
            3'h0:    next_s.rz_onehot = 5'h01;
            3'h1:    next_s.rz_onehot = 5'h02;
            3'h2:    next_s.rz_onehot = 5'h04;
            3'h3:    next_s.rz_onehot = 5'h08;
            default: next_s.rz_onehot = 5'h10;
         endcase
      end

      // Control state returns to defaults under reset
      // mode resets to 000
      if (!resetn_in)
      begin
         next_s.pri_lo    = ilsel_pkg::DIV_LO_RST;
         next_s.pri_hi    = ilsel_pkg::DIV_HI_RST;
         next_s.sec_lo    = ilsel_pkg::DIV_LO_RST;
         next_s.sec_hi    = ilsel_pkg::DIV_HI_RST;
         next_s.misc      = ilsel_pkg::MISC_RST;
         next_s.zres      = ilsel_pkg::ZRES_RST;
         next_s.sel       = ilsel_pkg::ILSEL_PRI;
         next_s.rdata     = 32'h00000000;
         next_s.pri_div   = 16'h0001;
         next_s.sec_div   = 16'h0001;
         next_s.tune_mid  = 1'b0;
         next_s.pump_tri  = 1'b0;
         next_s.rz_onehot = 5'h01;
         next_s.rz_ext    = 1'b0;
      end
   end

   assign pri_word = {s.pri_hi, s.pri_lo};
   assign sec_word = {s.sec_hi, s.sec_lo};

   // Single state register, synchronous reset folded into next_s
   always_ff @(posedge clk_in)
   begin
      s <= next_s;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata_out            = s.rdata;
   assign use_secondary_out     = s.sel == ilsel_pkg::ILSEL_SEC;
   assign primary_div_out       = s.pri_div;
   assign secondary_div_out     = s.sec_div;
   assign tune_midsupply_out    = s.tune_mid;
   assign pump_tristate_out     = s.pump_tri;
   assign zero_res_onehot_out   = s.rz_onehot;
   assign zero_res_external_out = s.rz_ext;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   indep_div_a: assert property (s.misc[7] && !s.misc[1] && sec_word > 16'h0001
      |=> secondary_div_out == $past(sec_word)) else $error("secondary ratio not own word");
   shared_div_a: assert property (!s.misc[7] && !s.misc[1] && pri_word > 16'h0001
      |=> secondary_div_out == $past(pri_word)) else $error("secondary ratio not primary word");
   mid_supply_a: assert property (clk_fail && s.misc[6]
      |=> tune_midsupply_out && !pump_tristate_out) else $error("no midsupply on failure");
   pump_tri_a: assert property (clk_fail && !s.misc[6]
      |=> pump_tristate_out && !tune_midsupply_out) else $error("pump not tristated");
   force_sel_a: assert property (s.misc[4:2] == 3'b010 ##1 s.misc[4:2] == 3'b010
      |-> !use_secondary_out) else $error("forced primary not used");
   revert_sel_a: assert property (s.misc[4:2] == 3'b001 && !primary_fail_in
      |=> !use_secondary_out) else $error("did not revert to primary");
   pin_sel_a: assert property (s.misc[4]
      |=> use_secondary_out == $past(ref_select_pin_in)) else $error("pin select ignored");
   sec_bypass_a: assert property (s.misc[1]
      |=> secondary_div_out == 16'h0001) else $error("secondary bypass failed");
   pri_bypass_a: assert property (s.misc[0]
      |=> primary_div_out == 16'h0001) else $error("primary bypass failed");
   zres_map_a: assert property (s.zres[3:0] == 4'h2
      |=> zero_res_onehot_out == 5'h04 && !zero_res_external_out) else $error("bad resistor decode");
   rsvd_zero_a: assert property (s.misc[5] == 1'b0 && s.zres[7:4] == 4'h0)
      else $error("reserved bit set");

   // ---------------------------------------------------------------
   // Checks on reset and the register bus
   // ---------------------------------------------------------------
   // Reset is synchronous, so the defaults show one edge after it is seen low
   reset_state_a: assert property (@(posedge clk_in) disable iff (1'b0)
      !resetn_in |=> s.misc == ilsel_pkg::MISC_RST && s.zres == ilsel_pkg::ZRES_RST
      && !use_secondary_out && primary_div_out == 16'h0001 && zero_res_onehot_out == 5'h01)
      else $error("reset defaults wrong");

   // A write lands at the end of its access cycle, reserved bits dropped
   misc_write_a: assert property (wr && paddr_in == ilsel_pkg::MISC_ADDR
      |=> s.misc == ($past(pwdata_in[7:0]) & ilsel_pkg::MISC_MASK))
      else $error("misc write lost");
   zres_write_a: assert property (wr && paddr_in == ilsel_pkg::ZRES_ADDR
      |=> s.zres == ($past(pwdata_in[7:0]) & ilsel_pkg::ZRES_MASK))
      else $error("resistor write lost");

   // Read data is the value seen in the setup cycle, not one written later
   misc_read_a: assert property (setup && paddr_in == ilsel_pkg::MISC_ADDR ##1 access
      |-> prdata_out == {24'h000000, $past(s.misc)} && !prdata_out[5])
      else $error("misc read back wrong");
   // Status shows the failure outputs as they stood at setup
   status_read_a: assert property (setup && paddr_in == ilsel_pkg::STATUS_ADDR ##1 access
      |-> prdata_out[3] == $past(pump_tristate_out)
      && prdata_out[2] == $past(tune_midsupply_out))
      else $error("status read back wrong");

   // ---------------------------------------------------------------
   // Checks on reference selection
   // ---------------------------------------------------------------
   // Forced secondary holds even while it reports a failure
   force_sec_a: assert property (s.misc[4:2] == 3'b011 ##1 s.misc[4:2] == 3'b011
      |-> use_secondary_out)
      else $error("forced secondary not used");
   // Nonrevertive stays on secondary while it is healthy
   nonrev_hold_a: assert property (s.misc[4:2] == 3'b000 && use_secondary_out && !secondary_fail_in
      |=> use_secondary_out)
      else $error("nonrevertive left secondary");
   // A failed primary hands over to a healthy secondary
   nonrev_leave_a: assert property (s.misc[4:2] == 3'b000 && !use_secondary_out
      && primary_fail_in && !secondary_fail_in |=> use_secondary_out)
      else $error("no switch away from failed primary");
   // Revertive mode still falls back while the primary is down
   revert_back_a: assert property (s.misc[4:2] == 3'b001 && primary_fail_in && !secondary_fail_in
      |=> use_secondary_out)
      else $error("no fallback to secondary");

   // ---------------------------------------------------------------
   // Checks on dividers and failure handling
   // ---------------------------------------------------------------
   // Normal primary division passes the word through unchanged
   pri_div_a: assert property (!s.misc[0] && pri_word > 16'h0001
      |=> primary_div_out == $past(pri_word))
      else $error("primary ratio not its word");
   // Words 0 and 1 already mean divide by one
   small_word_a: assert property (s.misc[7] && sec_word <= 16'h0001
      |=> secondary_div_out == 16'h0001)
      else $error("small secondary word not one");
   // Without a failure the tuning voltage stays with the loop
   no_fail_a: assert property (!clk_fail
      |=> !tune_midsupply_out && !pump_tristate_out)
      else $error("failure action without failure");

   // ---------------------------------------------------------------
   // Checks on the zero resistor decode
   // ---------------------------------------------------------------
   // Exactly one internal value, or none when the external part is used
   zres_883_a: assert property (s.zres[3:0] == 4'h0
      |=> zero_res_onehot_out == 5'h01 && !zero_res_external_out)
      else $error("code 0 decode wrong");
   zres_677_a: assert property (s.zres[3:0] == 4'h1
      |=> zero_res_onehot_out == 5'h02 && !zero_res_external_out)
      else $error("code 1 decode wrong");
   zres_135_a: assert property (s.zres[3:0] == 4'h3
      |=> zero_res_onehot_out == 5'h08 && !zero_res_external_out)
      else $error("code 3 decode wrong");
   // Four codes share the smallest internal value
   zres_10k_a: assert property (s.zres[3:2] == 2'b01
      |=> zero_res_onehot_out == 5'h10 && !zero_res_external_out)
      else $error("low value decode wrong");
   // Code 1000 and the unused codes above it hand over to the external part
   zres_ext_a: assert property (s.zres[3]
      |=> zero_res_external_out && zero_res_onehot_out == 5'h00)
      else $error("external decode wrong");

   // Scenarios the bench is expected to reach

   switch_sec_c: cover property (!use_secondary_out ##1 use_secondary_out);
   revert_pri_c: cover property (s.misc[4:2] == 3'b001 && use_secondary_out ##1 !use_secondary_out);
   pin_mode_c:   cover property (s.misc[4] && ref_select_pin_in ##1 use_secondary_out);
   ext_res_c:    cover property (zero_res_external_out);
   mid_supply_c: cover property (tune_midsupply_out);

endmodule // ilsel_ctrl

//--- ilsel_ctrl_tb_top.sv
`timescale 1ns/1ps
// One macro for every comparison; the expected value is taken before the call
`define CHK(nm, ex, gt) \
   begin \
      n_tests++; \
      if ((gt) !== (ex)) \
      begin \
         $display("BAD %s exp %h got %h", nm, ex, gt); \
         err_total++; \
      end \
   end
module ilsel_ctrl_tb_top;
   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic        clk_in, resetn_in, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pri_fail, sec_fail, fb_fail, sel_pin, use_sec, tune, pump, zr_ext;
   logic [15:0] pri_div, sec_div;
   logic [4:0]  zr_oh;
   logic        probe_req;
   logic [2:0]  probe_sel;
   logic [32:0] probe_val, e;
   logic [32:0] exp_q[$];
   int          err_total, n_tests, cyc, seed;
   logic [15:0] wp, ws;

   ilsel_ctrl i_ilsel_ctrl (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
      .pslverr_out(pslverr), .prdata_out(prdata), .primary_fail_in(pri_fail), .secondary_fail_in(sec_fail),
      .feedback_fail_in(fb_fail), .ref_select_pin_in(sel_pin), .use_secondary_out(use_sec),
      .primary_div_out(pri_div), .secondary_div_out(sec_div), .tune_midsupply_out(tune),
      .pump_tristate_out(pump), .zero_res_onehot_out(zr_oh), .zero_res_external_out(zr_ext));

   // Clock, 8 ns period
   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // Output views the probe can pick
   always_comb
   begin
      case (probe_sel)
         3'h0:    probe_val = {27'h0, zr_ext, zr_oh};
         3'h1:    probe_val = {17'h0, pri_div};
         3'h2:    probe_val = {17'h0, sec_div};
         default: probe_val = {30'h0, use_sec, tune, pump};
      endcase
   end

   // ----------------------------------------------------------
   // Monitor: oldest note against each result that appears
   // ----------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         e = exp_q.pop_front();
         `CHK("prdata", e, {pslverr, prdata})
      end
      if (probe_req)
      begin
         e = exp_q.pop_front();
         `CHK("probe", e, probe_val)
      end
   end

   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   // Request held until pready is sampled high, released only after
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk_in);
      penable <= 1'b1;
      // Ends once pready is sampled high; only the bench's cycle limit ends it if pready never rises
      do
      begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hf);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] ex);
      exp_q.push_back(ex);
      xfer(1'b0, a, 32'h0, 4'h0);
   endtask

   // Probe samples outputs two edges on, after the effective outputs settle
   task automatic pr(input logic [2:0] sel, input logic [32:0] ex);
      exp_q.push_back(ex);
      @(posedge clk_in);
      probe_req <= 1'b1;
      probe_sel <= sel;
      @(posedge clk_in);
      probe_req <= 1'b0;
   endtask

   task automatic report_and_stop;
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard, far beyond the roughly 170 cycles needed
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge clk_in);
         cyc++;
         if (cyc > 20000)
         begin
            err_total++;
            report_and_stop();
         end
      end
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial
   begin
      err_total = 0;
      n_tests   = 0;
      seed      = 50;
      resetn_in = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      pstrb     = 4'h0;
      pri_fail  = 1'b0;
      sec_fail  = 1'b0;
      fb_fail   = 1'b0;
      sel_pin   = 1'b0;
      probe_req = 1'b0;
      probe_sel = 3'h0;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      // Reset state, reserved bits, strobe-less write and unmapped read
      rd(ilsel_pkg::MISC_ADDR, 33'h0);
      pr(3'h0, 33'h01);
      wr(ilsel_pkg::MISC_ADDR, 32'h20);
      rd(ilsel_pkg::MISC_ADDR, 33'h0);
      wr(ilsel_pkg::ZRES_ADDR, 32'hf3);
      rd(ilsel_pkg::ZRES_ADDR, 33'h03);
      xfer(1'b1, ilsel_pkg::ZRES_ADDR, 32'h01, 4'h0);
      rd(ilsel_pkg::ZRES_ADDR, 33'h03);
      rd(8'h00, {1'b1, 32'h0});
      // Every resistor code, then external
      for (int c = 0; c < 8; c++)
      begin
         wr(ilsel_pkg::ZRES_ADDR, 32'(c));
         pr(3'h0, (c < 4) ? 33'(1 << c) : 33'h10);
      end
      wr(ilsel_pkg::ZRES_ADDR, 32'h08);
      pr(3'h0, 33'h20);
      rd(ilsel_pkg::ZRES_ADDR, 33'h08);
      // Random divider words, sharing, independence and bypass
      wp = 16'($random(seed)) | 16'h0002;
      ws = 16'($random(seed)) | 16'h0002;
      wr(ilsel_pkg::PRI_DIV_LO_ADDR, {24'h0, wp[7:0]});
      wr(ilsel_pkg::PRI_DIV_HI_ADDR, {24'h0, wp[15:8]});
      wr(ilsel_pkg::SEC_DIV_LO_ADDR, {24'h0, ws[7:0]});
      wr(ilsel_pkg::SEC_DIV_HI_ADDR, {24'h0, ws[15:8]});
      rd(ilsel_pkg::SEC_DIV_HI_ADDR, {25'h0, ws[15:8]});
      pr(3'h1, {17'h0, wp});
      pr(3'h2, {17'h0, wp});
      wr(ilsel_pkg::MISC_ADDR, 32'h80);
      pr(3'h2, {17'h0, ws});
      wr(ilsel_pkg::MISC_ADDR, 32'h81);
      pr(3'h1, 33'h1);
      pr(3'h2, {17'h0, ws});
      wr(ilsel_pkg::MISC_ADDR, 32'h82);
      pr(3'h2, 33'h1);
      pr(3'h1, {17'h0, wp});
      // Forced, pin, nonrevertive and revertive selection
      wr(ilsel_pkg::MISC_ADDR, 32'h0c);
      pr(3'h3, 33'h4);
      wr(ilsel_pkg::MISC_ADDR, 32'h1c);
      pr(3'h3, 33'h0);
      sel_pin <= 1'b1;
      pr(3'h3, 33'h4);
      wr(ilsel_pkg::MISC_ADDR, 32'h08);
      pr(3'h3, 33'h0);
      wr(ilsel_pkg::MISC_ADDR, 32'h00);
      pri_fail <= 1'b1;
      pr(3'h3, 33'h5);
      pri_fail <= 1'b0;
      pr(3'h3, 33'h4);
      pr(3'h3, 33'h4);
      wr(ilsel_pkg::MISC_ADDR, 32'h04);
      pr(3'h3, 33'h0);
      // Failure handling of the tuning voltage
      wr(ilsel_pkg::MISC_ADDR, 32'h48);
      fb_fail <= 1'b1;
      pr(3'h3, 33'h2);
      // Status: failure seen and midsupply forced, primary still active
      rd(ilsel_pkg::STATUS_ADDR, 33'h6);
      wr(ilsel_pkg::MISC_ADDR, 32'h08);
      pr(3'h3, 33'h1);
      fb_fail <= 1'b0;
      pr(3'h3, 33'h0);
      rd(ilsel_pkg::MISC_ADDR, 33'h08);
      repeat (3) @(posedge clk_in);
      if (exp_q.size() != 0)
         err_total++;
      report_and_stop();
   end
endmodule // ilsel_ctrl_tb_top

//--- ilsel_pkg.sv
// ---------------------------------------------------------------
// How it works
// - Independent bit set: secondary divider uses its own divider word.
// - Independent bit clear: secondary divider copies the primary divider word.
// - Bit 6 set: tuning voltage forced to midsupply on clock failure.
// - Bit 6 clear: charge pump tristated on clock failure.
// - Mode field resets to 000: nonrevertive, revertive, force primary, force secondary.
// - Mode bit 4 high: external select pin chooses, low primary, high secondary.
// - Bit 1 bypasses secondary divider, divide by one.
// - Bit 0 bypasses primary divider, divide by one.
// - Zero resistor code maps to 883, 677, 341, 135, 10 kOhm or external.
// ---------------------------------------------------------------
package ilsel_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] PRI_DIV_LO_IDX = 8'h10;
   localparam logic [7:0] PRI_DIV_HI_IDX = 8'h11;
   localparam logic [7:0] SEC_DIV_LO_IDX = 8'h12;
   localparam logic [7:0] SEC_DIV_HI_IDX = 8'h13;
   localparam logic [7:0] MISC_IDX       = 8'h1c;
   localparam logic [7:0] ZRES_IDX       = 8'h1d;
   localparam logic [7:0] STATUS_IDX     = 8'h20;

   localparam logic [7:0] PRI_DIV_LO_ADDR = 8'(PRI_DIV_LO_IDX * 4);
   localparam logic [7:0] PRI_DIV_HI_ADDR = 8'(PRI_DIV_HI_IDX * 4);
   localparam logic [7:0] SEC_DIV_LO_ADDR = 8'(SEC_DIV_LO_IDX * 4);
   localparam logic [7:0] SEC_DIV_HI_ADDR = 8'(SEC_DIV_HI_IDX * 4);
   localparam logic [7:0] MISC_ADDR       = 8'(MISC_IDX * 4);
   localparam logic [7:0] ZRES_ADDR       = 8'(ZRES_IDX * 4);
   localparam logic [7:0] STATUS_ADDR     = 8'(STATUS_IDX * 4);

   // Misc control field positions
   localparam int MISC_INDEP_BIT   = 7;
   localparam int MISC_MIDSUP_BIT  = 6;
   localparam int MISC_PIN_BIT     = 4;
   localparam int MISC_SEC_BYP_BIT = 1;
   localparam int MISC_PRI_BYP_BIT = 0;

   // Writable bit masks; reserved bits are cleared
   localparam logic [7:0] MISC_MASK = 8'hdf;
   localparam logic [7:0] ZRES_MASK = 8'h0f;

   // Values after reset
   localparam logic [7:0] MISC_RST   = 8'h00;
   localparam logic [7:0] ZRES_RST   = 8'h00;
   localparam logic [7:0] DIV_LO_RST = 8'h01;
   localparam logic [7:0] DIV_HI_RST = 8'h00;

   // Reference mode codes, bits 3:2 with bit 4 low
   localparam logic [1:0] MODE_NONREV = 2'h0;
   localparam logic [1:0] MODE_REVERT = 2'h1;
   localparam logic [1:0] MODE_PRI    = 2'h2;
   localparam logic [1:0] MODE_SEC    = 2'h3;

   // Active reference, one-hot
   typedef enum logic [1:0] {
      ILSEL_PRI = 2'b01,
      ILSEL_SEC = 2'b10
   } ilsel_ref_t;

endpackage
